// *** common/dbg_trace_pkg.sv ***
package dbg_trace_pkg;

  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_SESSION_CTRL = 10'h020;
  localparam logic [9:0] IDX_STATE_STATUS = 10'h021;
  localparam logic [9:0] IDX_TRACE_CFG = 10'h022;
  localparam logic [9:0] IDX_MATCH_MAP = 10'h023;
  localparam logic [9:0] IDX_TRACE_BUF = 10'h024;
  localparam logic [9:0] IDX_LINE_COUNT = 10'h026;

  // field positions
  localparam int ARM_BIT = 7;
  localparam int FULL_BIT = 7;
  localparam int TEN_BIT = 6;
  localparam int TMODE_LSB = 2;
  localparam int TRIGGER_ALIGNMENT_BIT_BIT = 0;
  localparam int MAP_LSB = 0;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] TRACE_CFG_RESET = 8'h00;
  localparam logic [7:0] MATCH_MAP_RESET = 8'h00;

  // trace buffer geometry
  localparam int BUF_LINES = 64;
  localparam int LINE_W = 20;

  // sequencer state flag codes
  localparam logic [2:0] SSF_DISARMED = 3'h0;
  localparam logic [2:0] SSF_ONE = 3'h1;
  localparam logic [2:0] SSF_TWO = 3'h2;
  localparam logic [2:0] SSF_THREE = 3'h3;
  localparam logic [2:0] SSF_FINAL = 3'h4;

  // trace modes
  localparam logic [1:0] TMODE_FLOW = 2'h0;
  localparam logic [1:0] TMODE_LOOP = 2'h1;
  localparam logic [1:0] TMODE_DETAIL = 2'h2;
  localparam logic [1:0] TMODE_PC = 2'h3;

  // match mapping codes
  localparam logic [1:0] MAP_SINGLE = 2'h0;
  localparam logic [1:0] MAP_INSIDE = 2'h1;
  localparam logic [1:0] MAP_OUTSIDE = 2'h2;
  localparam logic [1:0] MAP_RSVD = 2'h3;

  typedef enum logic [2:0] {
    seq_disarmed,
    seq_one,
    seq_two,
    seq_three,
    seq_final
  } seq_t;

endpackage

// *** hw/debug_trace_status_control.sv ***
`timescale 1ns/100ps
module debug_trace_status_control (
  input wire logic pclk, // bus clock
  input wire logic presetn, // power-on reset, active low
  input wire logic other_reset, // non power-on system reset, sync
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic secured, // system secured
  input wire logic seq_step, // sequencer transition request
  input wire logic [2:0] seq_dest, // requested state code
  input wire logic flow_valid, // change-of-flow line offered
  input wire logic flow_redundant, // offered flow line is a repeat
  input wire logic access_valid, // bus access line offered
  input wire logic pc_valid, // executed instruction line offered
  input wire logic [dbg_trace_pkg::LINE_W-1:0] trace_line, // line to store
  input wire logic cmp_a_hit, // comparator a match
  input wire logic cmp_b_hit, // comparator b match
  input wire logic addr_ge_a, // address at or above a
  input wire logic addr_le_b, // address at or below b
  output logic match0, // match output 0
  output logic match1, // match output 1
  output logic session_armed // debug session running
);
  import dbg_trace_pkg::*;

  typedef struct packed {
    // bus answer
    logic ready;
    logic slverr;
    logic [31:0] rdata;

    // session and sequencer
    logic armed;
    seq_t seq;
    logic [2:0] ssf;
    logic triggered;

    // fill state of the buffer
    logic full;
    logic [5:0] cnt;

    // read-out side
    logic [5:0] rptr;
    logic unlocked;

    // trace configuration
    logic ten;
    logic [1:0] tmode;
    logic trigger_alignment_bit;

    // match mapping and outputs
    logic [1:0] map;
    logic m0;
    logic m1;

    // trace line storage, one entry per line
    logic [BUF_LINES-1:0][LINE_W-1:0] mem;
  } state_t;

  // registered state and its next value
  state_t q;
  state_t d;

  // bus decode
  logic access;
  logic done;
  logic [9:0] idx;
  logic aligned;

  // trace read and store
  logic rd_ok;
  logic offer;
  logic store;

  // sequencer and comparator helpers
  logic in_range;
  logic legal_dest;
  logic seq_live;

  // software write strobe and byte
  logic sw_wr;
  logic [7:0] wb;

  // ==========================================================
  // helpers
  // requested code to sequencer state
  function automatic seq_t seq_of(input logic [2:0] code);
    case (code)
      SSF_ONE: seq_of = seq_one;
      SSF_TWO: seq_of = seq_two;
      SSF_THREE: seq_of = seq_three;
      SSF_FINAL: seq_of = seq_final;
      default: seq_of = seq_disarmed;
    endcase
  endfunction

  // flag code of a sequencer state, reserved codes never produced
  function automatic logic [2:0] code_of(input seq_t s);
    case (s)
      seq_one: code_of = SSF_ONE;
      seq_two: code_of = SSF_TWO;
      seq_three: code_of = SSF_THREE;
      seq_final: code_of = SSF_FINAL;
      default: code_of = SSF_DISARMED;
    endcase
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    // hold every register unless changed below
    d = q;
    // bus decode
    access = psel & penable;
    done = access & q.ready;
    idx = paddr[11:2];
    aligned = (paddr[1:0] == 2'h0);
    wb = pwdata[7:0];
    sw_wr = done & pwrite & aligned;
    // read gate, legal targets and a running sequencer
    rd_ok = q.unlocked & ~q.armed & q.ten & ~secured;
    legal_dest = (seq_dest >= SSF_ONE) && (seq_dest <= SSF_FINAL);
    seq_live = q.armed & (q.seq != seq_disarmed);

    // one wait state, answer on second access cycle
    d.ready = access & ~q.ready;
    d.slverr = 1'b0;
    if (access & ~q.ready) begin
      // unselected bits read zero
      d.rdata = 32'h0;
      d.slverr = ~aligned;
      // only whole aligned words decode
      if (aligned) begin
        case (idx)
          // session control shows only the arm bit
          IDX_SESSION_CTRL: d.rdata[ARM_BIT] = q.armed;

          // status: full flag, zero gap, state flags
          IDX_STATE_STATUS: begin
            d.rdata[FULL_BIT] = q.full;
            d.rdata[2:0] = q.ssf;
          end

          // trace configuration readback
          IDX_TRACE_CFG: begin
            d.rdata[TEN_BIT] = q.ten;
            d.rdata[TMODE_LSB+:2] = q.tmode;
            d.rdata[TRIGGER_ALIGNMENT_BIT_BIT] = q.trigger_alignment_bit;
          end

          // mapping field, readable at any time
          IDX_MATCH_MAP: d.rdata[MAP_LSB+:2] = q.map;

          // trace buffer, zero unless reading is allowed
          IDX_TRACE_BUF: begin
            if (rd_ok) begin
              d.rdata[LINE_W-1:0] = q.mem[q.rptr];
            end
          end

          // line count with the full flag on top
          IDX_LINE_COUNT: begin
            d.rdata[FULL_BIT] = q.full;
            d.rdata[5:0] = q.cnt;
          end
          default: d.slverr = 1'b1;
        endcase
      end
    end

    // buffer read advances pointer only on a valid read
    if (done & ~pwrite & aligned & (idx == IDX_TRACE_BUF) & rd_ok) begin
      d.rptr = q.rptr + 6'h1;
    end

    // sequencer transitions, only to a defined state
    if (seq_live & seq_step & legal_dest) begin
      d.seq = seq_of(seq_dest);
      d.ssf = code_of(d.seq);
      // final state marks the trigger
      if (seq_dest == SSF_FINAL) begin
        d.triggered = 1'b1;
        // end-aligned or untraced session finishes at the trigger
        if (~q.trigger_alignment_bit | ~q.ten | secured) begin
          d.armed = 1'b0;
          d.seq = seq_disarmed;
          d.ssf = SSF_DISARMED;
        end
      end
    end

    // trace storage, selected by mode
    case (q.tmode)
      TMODE_FLOW: offer = flow_valid;
      TMODE_LOOP: offer = flow_valid & ~flow_redundant;
      TMODE_DETAIL: offer = access_valid;
      TMODE_PC: offer = pc_valid;
      default: offer = 1'b0;
    endcase
    // store while armed, enabled, unsecured and on the aligned side of the trigger
    store = offer & q.armed & q.ten & ~secured
      & (q.trigger_alignment_bit ? q.triggered : ~q.triggered);
    // line lands at the count, count wraps at the end of the buffer
    if (store) begin
      d.mem[q.cnt] = trace_line;
      d.cnt = q.cnt + 6'h1;
      // last entry filled; end-aligned sessions wrap and keep storing
      if (q.cnt == 6'h3f) begin
        d.full = 1'b1;
        // begin-aligned session ends once the buffer has filled
        if (q.trigger_alignment_bit) begin
          d.armed = 1'b0;
          d.seq = seq_disarmed;
          d.ssf = SSF_DISARMED;
        end
      end
    end

    // software writes
    if (sw_wr) begin
      case (idx)
        IDX_SESSION_CTRL: begin
          // arming starts a fresh session, wins over a same-cycle end
          if (wb[ARM_BIT]) begin
            d.armed = 1'b1;
            d.seq = seq_one;
            d.ssf = SSF_ONE;
            d.full = 1'b0;
            // count and trigger start over, buffer locked again
            d.cnt = 6'h0;
            d.triggered = 1'b0;
            d.unlocked = 1'b0;
          end else begin
            // software disarm keeps the flags
            d.armed = 1'b0;
            d.seq = seq_disarmed;
          end
        end

        IDX_TRACE_CFG: begin
          // enable needs an unsecured, disarmed unit
          if (~q.armed & ~secured) begin
            d.ten = wb[TEN_BIT];
          end
          // mode and alignment need a disarmed unit
          if (~q.armed) begin
            d.tmode = wb[TMODE_LSB+:2];
            d.trigger_alignment_bit = wb[TRIGGER_ALIGNMENT_BIT_BIT];
          end
        end

        // mapping fixed while armed
        IDX_MATCH_MAP: begin
          if (~q.armed) begin
            d.map = wb[MAP_LSB+:2];
          end
        end

        // unlock for reading, starting at the oldest line
        IDX_TRACE_BUF: begin
          if (~q.armed) begin
            d.unlocked = 1'b1;
            d.rptr = q.full ? q.cnt : 6'h0;
          end
        end

        // other words have no write effect
        default: d.unlocked = d.unlocked;
      endcase
    end

    // secure mode holds a cleared enable at zero, a set enable stays set
    if (secured & ~q.ten) begin
      d.ten = 1'b0;
    end

    // comparator match mapping
    in_range = addr_ge_a & addr_le_b;
    case (q.map)
      // a and b on their own outputs
      MAP_SINGLE: begin
        d.m0 = cmp_a_hit;
        d.m1 = cmp_b_hit;
      end

      // inside the a to b range
      MAP_INSIDE: begin
        d.m0 = access_valid & in_range;
        d.m1 = 1'b0;
      end

      // outside the a to b range
      MAP_OUTSIDE: begin
        d.m0 = access_valid & ~in_range;
        d.m1 = 1'b0;
      end

      // reserved code acts as a alone
      default: begin
        d.m0 = cmp_a_hit;
        d.m1 = 1'b0;
      end
    endcase

    // other resets clear control and flags, keep fill state and buffer
    if (other_reset) begin
      // bus answer dropped
      d.ready = 1'b0;
      d.slverr = 1'b0;
      d.rdata = 32'h0;
      // session and flags cleared
      d.armed = 1'b0;
      d.seq = seq_disarmed;
      d.ssf = SSF_DISARMED;
      d.triggered = 1'b0;
      d.unlocked = 1'b0;
      // configuration back to its reset value
      d.ten = TRACE_CFG_RESET[TEN_BIT];
      d.tmode = TRACE_CFG_RESET[TMODE_LSB+:2];
      d.trigger_alignment_bit = TRACE_CFG_RESET[TRIGGER_ALIGNMENT_BIT_BIT];
      d.map = MATCH_MAP_RESET[MAP_LSB+:2];
      d.m0 = 1'b0;
      d.m1 = 1'b0;
      d.full = q.full;
    end
  end

  // ==========================================================
  // state register, power-on reset clears everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slverr;
  // match outputs and session state
  assign match0 = q.m0;
  assign match1 = q.m1;
  assign session_armed = q.armed;

endmodule

// *** verification/debug_trace_status_control_sva.sv ***
`timescale 1ns/100ps
// ==========
// bus and output checks
module debug_trace_status_control_sva (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic access_valid, // access offer
  input wire logic cmp_a_hit, // comparator a
  input wire logic cmp_b_hit, // comparator b
  input wire logic match0, // match 0
  input wire logic match1, // match 1
  input wire logic session_armed // armed
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed reads, and completed writes to session control
  wire rd = psel && penable && pready && !pwrite;
  wire wr = psel && penable && pready && pwrite && paddr == 12'h080;
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_status_zero: assert property (rd && paddr == 12'h084 |-> prdata[6:3] == 4'h0)
    else $error("status gap bits set");
  a_state_legal: assert property (rd && paddr == 12'h084 |-> prdata[2:0] <= 3'h4)
    else $error("reserved state code");
  a_armed_read: assert property (rd && paddr == 12'h090 && session_armed |-> prdata == '0)
    else $error("buffer read while armed");
  a_arm_write: assert property (wr && pwdata[7] |=> session_armed)
    else $error("arm lost");
  a_disarm_write: assert property (wr && !pwdata[7] |=> !session_armed)
    else $error("disarm lost");
  a_match0_off: assert property (!cmp_a_hit && !access_valid |=> !match0)
    else $error("match 0 without cause");
  a_match1_off: assert property (!cmp_b_hit |=> !match1)
    else $error("match 1 without cause");
endmodule
bind debug_trace_status_control debug_trace_status_control_sva sva_u (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .access_valid(access_valid),
  .cmp_a_hit(cmp_a_hit),
  .cmp_b_hit(cmp_b_hit),
  .match0(match0),
  .match1(match1),
  .session_armed(session_armed)
);

// *** verification/debug_trace_status_control_tb.sv ***
`timescale 1ns/100ps
// ==========
// bench
module debug_trace_status_control_tb;
  import dbg_trace_pkg::*;
  localparam logic [11:0] SCR = {IDX_SESSION_CTRL, 2'b00};
  localparam logic [11:0] STA = {IDX_STATE_STATUS, 2'b00};
  localparam logic [11:0] CFG = {IDX_TRACE_CFG, 2'b00};
  localparam logic [11:0] MAP = {IDX_MATCH_MAP, 2'b00};
  localparam logic [11:0] BUF = {IDX_TRACE_BUF, 2'b00};
  localparam logic [11:0] CNT = {IDX_LINE_COUNT, 2'b00};
  logic pclk = '0, presetn = '0, other_reset = '0, psel = '0, penable = '0;
  logic pwrite = '0, secured = '0, seq_step = '0, flow_valid = '0;
  logic flow_redundant = '0, access_valid = '0, pc_valid = '0;
  logic cmp_a_hit = '0, cmp_b_hit = '0, addr_ge_a = '0, addr_le_b = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [2:0] seq_dest = '0;
  logic [LINE_W-1:0] trace_line = '0;
  logic pready, pslverr, er, match0, match1, session_armed;
  int n_errors = 0, tests_run = 0, ln = 0;
  // clock
  always #4 pclk = ~pclk;
  debug_trace_status_control dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .other_reset(other_reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .secured(secured),
    .seq_step(seq_step),
    .seq_dest(seq_dest),
    .flow_valid(flow_valid),
    .flow_redundant(flow_redundant),
    .access_valid(access_valid),
    .pc_valid(pc_valid),
    .trace_line(trace_line),
    .cmp_a_hit(cmp_a_hit),
    .cmp_b_hit(cmp_b_hit),
    .addr_ge_a(addr_ge_a),
    .addr_le_b(addr_le_b),
    .match0(match0),
    .match1(match1),
    .session_armed(session_armed)
  );
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    er = pslverr;
    if (pready !== 1'b1) n_errors++; // bus wait ran out
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h0);
    chk(r, e);
  endtask
  task automatic step(input logic [2:0] d);
    seq_dest <= d;
    seq_step <= 1'b1;
    @(posedge pclk);
    seq_step <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic ofr(input logic [3:0] v);
    {flow_valid, flow_redundant, access_valid, pc_valid} <= v;
    @(posedge pclk);
    {flow_valid, flow_redundant, access_valid, pc_valid} <= 4'h0;
    @(posedge pclk);
  endtask
  task automatic fill(input int n);
    repeat (n) begin
      trace_line <= 20'h100 + ln[19:0];
      flow_valid <= 1'b1;
      ln++;
      @(posedge pclk);
    end
    flow_valid <= 1'b0;
  endtask
  task automatic t_regs;
    rc(STA, 32'h0);
    rc(CFG, 32'h0);
    rc(MAP, 32'h0);
    wr(STA, 8'hff);
    rc(STA, 32'h0);
    apb(1'b0, 12'h0fc, 8'h0);
    chk(er, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_cfg;
    secured <= 1'b1;
    wr(CFG, 8'h4d);
    rc(CFG, 32'h0d);
    secured <= 1'b0;
    wr(CFG, 8'h4d);
    rc(CFG, 32'h4d);
    wr(MAP, 8'h02);
    wr(SCR, 8'h80);
    wr(CFG, 8'h00);
    wr(MAP, 8'h01);
    rc(CFG, 32'h4d);
    rc(MAP, 32'h02);
    wr(SCR, 8'h00);
    $display("t_cfg done");
  endtask
  task automatic t_seq;
    wr(SCR, 8'h80);
    rc(STA, 32'h01);
    step(3'h2);
    rc(STA, 32'h02);
    step(3'h3);
    step(3'h5);
    rc(STA, 32'h03);
    wr(SCR, 8'h00);
    rc(STA, 32'h03);
    wr(CFG, 8'h40);
    wr(SCR, 8'h80);
    step(3'h4);
    chk(session_armed, 32'h0);
    rc(STA, 32'h0);
    $display("t_seq done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(CFG, {4'h4, m[1:0], 2'h0});
      wr(SCR, 8'h80);
      ofr(4'h8);
      ofr(4'hc);
      ofr(4'h2);
      ofr(4'h1);
      wr(SCR, 8'h00);
      rc(CNT, {30'h0, m == 0, m != 0});
    end
    $display("t_modes done");
  endtask
  task automatic t_align;
    wr(CFG, 8'h41);
    wr(SCR, 8'h80);
    ofr(4'h8);
    rc(CNT, 32'h0);
    step(3'h4);
    ofr(4'h8);
    rc(CNT, 32'h1);
    chk(session_armed, 32'h1);
    wr(SCR, 8'h00);
    $display("t_align done");
  endtask
  task automatic t_full;
    wr(CFG, 8'h40);
    wr(SCR, 8'h80);
    fill(63);
    rc(CNT, 32'h3f);
    fill(1);
    rc(STA, 32'h81);
    rc(CNT, 32'h80);
    rc(BUF, 32'h0);
    wr(SCR, 8'h00);
    wr(BUF, 8'h00);
    rc(BUF, 32'h100);
    rc(BUF, 32'h101);
    wr(CFG, 8'h00);
    rc(BUF, 32'h0);
    other_reset <= 1'b1;
    @(posedge pclk);
    other_reset <= 1'b0;
    @(posedge pclk);
    rc(STA, 32'h80);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(STA, 32'h0);
    rc(CNT, 32'h0);
    wr(CFG, 8'h40);
    wr(SCR, 8'h80);
    fill(64);
    rc(STA, 32'h81);
    wr(SCR, 8'h80);
    rc(STA, 32'h01);
    wr(SCR, 8'h00);
    $display("t_full done");
  endtask
  task automatic t_match;
    for (int c = 0; c < 4; c++) begin
      wr(MAP, {6'h0, c[1:0]});
      {cmp_a_hit, cmp_b_hit, access_valid, addr_ge_a, addr_le_b} <= 5'h1f;
      repeat (2) @(posedge pclk);
      chk({match0, match1}, {4'hb >> c, c == 0} & 32'h3);
      {cmp_a_hit, cmp_b_hit, access_valid, addr_ge_a, addr_le_b} <= 5'h05;
      repeat (2) @(posedge pclk);
      chk({match0, match1}, {c == 2, 1'b0});
      {cmp_a_hit, cmp_b_hit, access_valid, addr_ge_a, addr_le_b} <= 5'h10;
      repeat (2) @(posedge pclk);
      chk({match0, match1}, {c == 0 || c == 3, 1'b0});
    end
    {cmp_a_hit, cmp_b_hit, access_valid, addr_ge_a, addr_le_b} <= 5'h00;
    $display("t_match done");
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_cfg;
    t_seq;
    t_modes;
    t_align;
    t_full;
    t_match;
    end_sim;
  end
  // watchdog
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
endmodule
